// ==== pcint_defines.vh ====
`ifndef PCINT_DEFINES_VH
`define PCINT_DEFINES_VH

// register byte offsets on the apb window
`define PCINT_OFF_PORTA_RISE 8'h00
`define PCINT_OFF_PORTA_FALL 8'h04
`define PCINT_OFF_PORTA_FLAGS 8'h08
`define PCINT_OFF_PORTB_RISE 8'h0C
`define PCINT_OFF_PORTB_FALL 8'h10
`define PCINT_OFF_PORTB_FLAGS 8'h14
`define PCINT_OFF_PORTC_RISE 8'h18
`define PCINT_OFF_PORTC_FALL 8'h1C
`define PCINT_OFF_PORTC_FLAGS 8'h20
`define PCINT_OFF_PORTE_RISE 8'h24
`define PCINT_OFF_PORTE_FALL 8'h28
`define PCINT_OFF_PORTE_FLAGS 8'h2C
`define PCINT_OFF_PERIPHERAL_IRQ_ENABLE_0 8'h30
`define PCINT_OFF_PERIPHERAL_IRQ_REQUEST_0 8'h34
`define PCINT_OFF_IRQ_STATUS 8'h38
`define PCINT_OFF_IRQ_MASK 8'h3C

// field positions
`define PCINT_MASTER_EN_BIT 4
`define PCINT_SUMMARY_BIT 4
`define PCINT_PORTA_EVT_BIT 0
`define PCINT_PORTB_EVT_BIT 1
`define PCINT_PORTC_EVT_BIT 2
`define PCINT_PORTE_EVT_BIT 3

// implemented and available bit masks
`define PCINT_FULL_MASK 8'hFF
`define PCINT_PORTE_IMPL_MASK 8'h08
`define PCINT_PORTB_DEBUG_MASK 8'h3F

// reset values
`define PCINT_RESET_BYTE 8'h00
`define PCINT_RESET_EVT 4'h0
`define PCINT_RESET_WORD 32'h0000_0000

`endif

// ==== pcint_port_edge.v ====
`timescale 1ns/100ps
`default_nettype none

// one port: pin synchroniser, edge detectors and flag register
module pcint_port_edge #(
	parameter WIDTH = 8
) (
	input wire pclk,
	input wire presetn,
	input wire [WIDTH-1:0] pins,
	input wire [WIDTH-1:0] rise_en,
	input wire [WIDTH-1:0] fall_en,
	input wire [WIDTH-1:0] avail,
	input wire flag_wr,
	input wire [WIDTH-1:0] flag_wdata,
	output wire [WIDTH-1:0] flags,
	output wire [WIDTH-1:0] edge_seen
);

reg [WIDTH-1:0] sync1_reg; // first stage, read only by sync2
reg [WIDTH-1:0] sync2_reg; // settled sample
reg [WIDTH-1:0] prev_reg; // previous settled sample
reg [WIDTH-1:0] flags_reg; // per-pin change flags
reg [WIDTH-1:0] flags_next;
wire [WIDTH-1:0] rise_hit;
wire [WIDTH-1:0] fall_hit;

// two flops before any logic sees a pin, then one more for history
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		sync1_reg <= {WIDTH{1'b0}};
		sync2_reg <= {WIDTH{1'b0}};
		prev_reg <= {WIDTH{1'b0}};
	end else begin
		sync1_reg <= pins;
		sync2_reg <= sync1_reg;
		prev_reg <= sync2_reg;
	end
end

// compare current and previous sample: one hit per transition
assign rise_hit = sync2_reg & ~prev_reg & rise_en & avail;
assign fall_hit = ~sync2_reg & prev_reg & fall_en & avail;
assign edge_seen = rise_hit | fall_hit;

// software write first, hardware set on top so a fresh edge survives
always @* begin
	flags_next = flags_reg;
	if (flag_wr) begin
		flags_next = flag_wdata;
	end
	flags_next = (flags_next | edge_seen) & avail;
end

// flags update regardless of the master enable
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		flags_reg <= {WIDTH{1'b0}};
	end else begin
		flags_reg <= flags_next;
	end
end

assign flags = flags_reg;

endmodule // pcint_port_edge

`default_nettype wire

// ==== pcint_ctrl.v ====
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "pcint_defines.vh"

module pcint_ctrl #(
	parameter ADDR_W = 8
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire [7:0] porta_pins,
	input wire [7:0] portb_pins,
	input wire [7:0] portc_pins,
	input wire [3:0] porte_pins,
	input wire debugger_enable,
	input wire reset_pin_function_enable,
	input wire low_voltage_programming,
	output wire change_irq_request,
	output wire wake_request,
	output wire irq
);

// software-written enables, one byte per port and edge
reg [7:0] porta_rise_enable_reg;
reg [7:0] porta_fall_enable_reg;
reg [7:0] portb_rise_enable_reg;
reg [7:0] portb_fall_enable_reg;
reg [7:0] portc_rise_enable_reg;
reg [7:0] portc_fall_enable_reg;
reg [7:0] porte_rise_enable_reg;
reg [7:0] porte_fall_enable_reg;
reg change_irq_master_enable_reg; // bit of peripheral_irq_enable_0
reg [3:0] irq_status_reg; // sticky per-port events
reg [3:0] irq_status_next;
reg [3:0] irq_mask_reg; // gates status onto irq
reg [31:0] prdata_reg; // read data, loaded in setup phase

// decoded write strobes
reg wr_a_rise;
reg wr_a_fall;
reg wr_a_flags;
reg wr_b_rise;
reg wr_b_fall;
reg wr_b_flags;
reg wr_c_rise;
reg wr_c_fall;
reg wr_c_flags;
reg wr_e_rise;
reg wr_e_fall;
reg wr_e_flags;
reg wr_peripheral_irq_enable_0;
reg wr_status;
reg wr_mask;

// read mux result and hit flag
reg [31:0] rd_data;
reg addr_mapped;

wire [7:0] porta_change_flags;
wire [7:0] portb_change_flags;
wire [7:0] portc_change_flags;
wire [7:0] porte_change_flags;
wire [7:0] edge_a;
wire [7:0] edge_b;
wire [7:0] edge_c;
wire [7:0] edge_e;
wire [7:0] avail_b;
wire [7:0] avail_e;
wire [3:0] port_event;
wire change_irq_summary;
wire wr_access;
wire setup_phase;

// byte compare on the low address bits; upper bits must be zero
function hit;
	input [ADDR_W-1:0] addr;
	input [7:0] off;
	begin
		hit = (addr == {{(ADDR_W-8){1'b0}}, off});
	end
endfunction

// a write lands only at the access edge; pready is always high
assign wr_access = psel & penable & pwrite;
assign setup_phase = psel & ~penable;

// debugger owns port B top two pins
assign avail_b = debugger_enable ? `PCINT_PORTB_DEBUG_MASK : `PCINT_FULL_MASK;

// port E: bit 3 only, lost to reset pin or lvp
assign avail_e = (reset_pin_function_enable | low_voltage_programming) ?
	`PCINT_RESET_BYTE : `PCINT_PORTE_IMPL_MASK;

// address decode into write strobes
always @* begin
	wr_a_rise = 1'b0;
	wr_a_fall = 1'b0;
	wr_a_flags = 1'b0;
	wr_b_rise = 1'b0;
	wr_b_fall = 1'b0;
	wr_b_flags = 1'b0;
	wr_c_rise = 1'b0;
	wr_c_fall = 1'b0;
	wr_c_flags = 1'b0;
	wr_e_rise = 1'b0;
	wr_e_fall = 1'b0;
	wr_e_flags = 1'b0;
	wr_peripheral_irq_enable_0 = 1'b0;
	wr_status = 1'b0;
	wr_mask = 1'b0;
	if (!wr_access) begin
		// idle or read: nothing to strobe
	end else if (hit(paddr, `PCINT_OFF_PORTA_RISE)) begin
		wr_a_rise = 1'b1;
	end else if (hit(paddr, `PCINT_OFF_PORTA_FALL)) begin
		wr_a_fall = 1'b1;
	end else if (hit(paddr, `PCINT_OFF_PORTA_FLAGS)) begin
		wr_a_flags = 1'b1;
	end else if (hit(paddr, `PCINT_OFF_PORTB_RISE)) begin
		wr_b_rise = 1'b1;
	end else if (hit(paddr, `PCINT_OFF_PORTB_FALL)) begin
		wr_b_fall = 1'b1;
	end else if (hit(paddr, `PCINT_OFF_PORTB_FLAGS)) begin
		wr_b_flags = 1'b1;
	end else if (hit(paddr, `PCINT_OFF_PORTC_RISE)) begin
		wr_c_rise = 1'b1;
	end else if (hit(paddr, `PCINT_OFF_PORTC_FALL)) begin
		wr_c_fall = 1'b1;
	end else if (hit(paddr, `PCINT_OFF_PORTC_FLAGS)) begin
		wr_c_flags = 1'b1;
	end else if (hit(paddr, `PCINT_OFF_PORTE_RISE)) begin
		wr_e_rise = 1'b1;
	end else if (hit(paddr, `PCINT_OFF_PORTE_FALL)) begin
		wr_e_fall = 1'b1;
	end else if (hit(paddr, `PCINT_OFF_PORTE_FLAGS)) begin
		wr_e_flags = 1'b1;
	end else if (hit(paddr, `PCINT_OFF_PERIPHERAL_IRQ_ENABLE_0)) begin
		wr_peripheral_irq_enable_0 = 1'b1;
	end else if (hit(paddr, `PCINT_OFF_IRQ_STATUS)) begin
		wr_status = 1'b1;
	end else if (hit(paddr, `PCINT_OFF_IRQ_MASK)) begin
		wr_mask = 1'b1;
	end
	// the summary register is read only; writes there are dropped
end

// enable registers; port E bits other than bit 3 never stick, port B debugger bits clear one clock after a write
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		porta_rise_enable_reg <= `PCINT_RESET_BYTE;
		porta_fall_enable_reg <= `PCINT_RESET_BYTE;
		portb_rise_enable_reg <= `PCINT_RESET_BYTE;
		portb_fall_enable_reg <= `PCINT_RESET_BYTE;
		portc_rise_enable_reg <= `PCINT_RESET_BYTE;
		portc_fall_enable_reg <= `PCINT_RESET_BYTE;
		porte_rise_enable_reg <= `PCINT_RESET_BYTE;
		porte_fall_enable_reg <= `PCINT_RESET_BYTE;
		change_irq_master_enable_reg <= 1'b0;
		irq_mask_reg <= `PCINT_RESET_EVT;
	end else begin
		// bit n of each byte is pin n
		if (wr_a_rise) begin
			porta_rise_enable_reg <= pwdata[7:0];
		end
		if (wr_a_fall) begin
			porta_fall_enable_reg <= pwdata[7:0];
		end
		if (wr_b_rise) begin
			portb_rise_enable_reg <= pwdata[7:0];
		end else begin
			portb_rise_enable_reg <= portb_rise_enable_reg & avail_b;
		end
		if (wr_b_fall) begin
			portb_fall_enable_reg <= pwdata[7:0];
		end else begin
			portb_fall_enable_reg <= portb_fall_enable_reg & avail_b;
		end
		if (wr_c_rise) begin
			portc_rise_enable_reg <= pwdata[7:0];
		end
		if (wr_c_fall) begin
			portc_fall_enable_reg <= pwdata[7:0];
		end
		// port E keeps only its one implemented bit
		if (wr_e_rise) begin
			porte_rise_enable_reg <= pwdata[7:0] & `PCINT_PORTE_IMPL_MASK;
		end
		if (wr_e_fall) begin
			porte_fall_enable_reg <= pwdata[7:0] & `PCINT_PORTE_IMPL_MASK;
		end
		if (wr_peripheral_irq_enable_0) begin
			change_irq_master_enable_reg <= pwdata[`PCINT_MASTER_EN_BIT];
		end
		if (wr_mask) begin
			irq_mask_reg <= pwdata[3:0];
		end
	end
end

// one detector slice per port
pcint_port_edge #(
	.WIDTH(8)
) u_porta (
	.pclk(pclk),
	.presetn(presetn),
	.pins(porta_pins),
	.rise_en(porta_rise_enable_reg),
	.fall_en(porta_fall_enable_reg),
	.avail(`PCINT_FULL_MASK),
	.flag_wr(wr_a_flags),
	.flag_wdata(pwdata[7:0]),
	.flags(porta_change_flags),
	.edge_seen(edge_a)
);

pcint_port_edge #(
	.WIDTH(8)
) u_portb (
	.pclk(pclk),
	.presetn(presetn),
	.pins(portb_pins),
	.rise_en(portb_rise_enable_reg),
	.fall_en(portb_fall_enable_reg),
	.avail(avail_b),
	.flag_wr(wr_b_flags),
	.flag_wdata(pwdata[7:0]),
	.flags(portb_change_flags),
	.edge_seen(edge_b)
);

pcint_port_edge #(
	.WIDTH(8)
) u_portc (
	.pclk(pclk),
	.presetn(presetn),
	.pins(portc_pins),
	.rise_en(portc_rise_enable_reg),
	.fall_en(portc_fall_enable_reg),
	.avail(`PCINT_FULL_MASK),
	.flag_wr(wr_c_flags),
	.flag_wdata(pwdata[7:0]),
	.flags(portc_change_flags),
	.edge_seen(edge_c)
);

// low nibble of port E comes in; only bit 3 can ever flag
pcint_port_edge #(
	.WIDTH(8)
) u_porte (
	.pclk(pclk),
	.presetn(presetn),
	.pins({4'h0, porte_pins}),
	.rise_en(porte_rise_enable_reg),
	.fall_en(porte_fall_enable_reg),
	.avail(avail_e),
	.flag_wr(wr_e_flags),
	.flag_wdata(pwdata[7:0]),
	.flags(porte_change_flags),
	.edge_seen(edge_e)
);

// summary is plain OR of every flag, independent of master enable
assign change_irq_summary = |{porta_change_flags, portb_change_flags,
	portc_change_flags, porte_change_flags};

// request to the core only through the master enable
assign change_irq_request = change_irq_summary & change_irq_master_enable_reg;

// wake is held as long as a pending flag is enabled, so a late
// sleep entry still sees it
assign wake_request = change_irq_summary & change_irq_master_enable_reg;

// per-port events for the sticky status
assign port_event[`PCINT_PORTA_EVT_BIT] = |edge_a;
assign port_event[`PCINT_PORTB_EVT_BIT] = |edge_b;
assign port_event[`PCINT_PORTC_EVT_BIT] = |edge_c;
assign port_event[`PCINT_PORTE_EVT_BIT] = |edge_e;

// write-one-to-clear, a same-cycle event wins over the clear
always @* begin
	irq_status_next = irq_status_reg;
	if (wr_status) begin
		irq_status_next = irq_status_next & ~pwdata[3:0];
	end
	irq_status_next = irq_status_next | port_event;
end

// sticky status register
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		irq_status_reg <= `PCINT_RESET_EVT;
	end else begin
		irq_status_reg <= irq_status_next;
	end
end

// masked status, also held off by the master enable
assign irq = (|(irq_status_reg & irq_mask_reg)) & change_irq_master_enable_reg;

// read mux; unmapped reads return zero with an error
always @* begin
	rd_data = `PCINT_RESET_WORD;
	addr_mapped = 1'b1;
	if (hit(paddr, `PCINT_OFF_PORTA_RISE)) begin
		rd_data[7:0] = porta_rise_enable_reg;
	end else if (hit(paddr, `PCINT_OFF_PORTA_FALL)) begin
		rd_data[7:0] = porta_fall_enable_reg;
	end else if (hit(paddr, `PCINT_OFF_PORTA_FLAGS)) begin
		rd_data[7:0] = porta_change_flags;
	end else if (hit(paddr, `PCINT_OFF_PORTB_RISE)) begin
		rd_data[7:0] = portb_rise_enable_reg & avail_b;
	end else if (hit(paddr, `PCINT_OFF_PORTB_FALL)) begin
		rd_data[7:0] = portb_fall_enable_reg & avail_b;
	end else if (hit(paddr, `PCINT_OFF_PORTB_FLAGS)) begin
		rd_data[7:0] = portb_change_flags;
	end else if (hit(paddr, `PCINT_OFF_PORTC_RISE)) begin
		rd_data[7:0] = portc_rise_enable_reg;
	end else if (hit(paddr, `PCINT_OFF_PORTC_FALL)) begin
		rd_data[7:0] = portc_fall_enable_reg;
	end else if (hit(paddr, `PCINT_OFF_PORTC_FLAGS)) begin
		rd_data[7:0] = portc_change_flags;
	end else if (hit(paddr, `PCINT_OFF_PORTE_RISE)) begin
		rd_data[7:0] = porte_rise_enable_reg;
	end else if (hit(paddr, `PCINT_OFF_PORTE_FALL)) begin
		rd_data[7:0] = porte_fall_enable_reg;
	end else if (hit(paddr, `PCINT_OFF_PORTE_FLAGS)) begin
		rd_data[7:0] = porte_change_flags;
	end else if (hit(paddr, `PCINT_OFF_PERIPHERAL_IRQ_ENABLE_0)) begin
		rd_data[`PCINT_MASTER_EN_BIT] = change_irq_master_enable_reg;
	end else if (hit(paddr, `PCINT_OFF_PERIPHERAL_IRQ_REQUEST_0)) begin
		rd_data[`PCINT_SUMMARY_BIT] = change_irq_summary;
	end else if (hit(paddr, `PCINT_OFF_IRQ_STATUS)) begin
		rd_data[3:0] = irq_status_reg;
	end else if (hit(paddr, `PCINT_OFF_IRQ_MASK)) begin
		rd_data[3:0] = irq_mask_reg;
	end else begin
		addr_mapped = 1'b0;
	end
end

// capture read data in the setup cycle so it is a flop output
// during the access cycle; costs nothing since pready is constant
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		prdata_reg <= `PCINT_RESET_WORD;
	end else if (setup_phase && !pwrite) begin
		prdata_reg <= rd_data;
	end
end

assign prdata = prdata_reg;
assign pready = 1'b1;
// error only in the access cycle, for any unmapped address
assign pslverr = psel & penable & ~addr_mapped;

endmodule // pcint_ctrl

`default_nettype wire

// ==== pcint_pins_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// far side of the block: the port pins as the outside world drives them
module pcint_pins_model (
	input wire logic pclk,
	output var logic [7:0] porta_pins,
	output var logic [7:0] portb_pins,
	output var logic [7:0] portc_pins,
	output var logic [3:0] porte_pins
);
	// pins idle low, matching the synchronisers' reset level
	initial begin
		porta_pins = 8'h00;
		portb_pins = 8'h00;
		portc_pins = 8'h00;
		porte_pins = 4'h0;
	end
	// new level lands just after an edge; callers hold it well over two clocks
	task automatic drive(input int port, input logic [7:0] v);
		@(posedge pclk);
		case (port)
			0: porta_pins <= v;
			1: portb_pins <= v;
			2: portc_pins <= v;
			default: porte_pins <= v[3:0];
		endcase
	endtask
endmodule // pcint_pins_model
`default_nettype wire

// ==== pcint_ctrl_properties.sv ====
`timescale 1ns/100ps
`default_nettype none
// watches the bus side and the request lines of the change block
module pcint_ctrl_properties #(
	parameter ADDR_W = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic [7:0] porta_pins,
	input wire logic [7:0] portb_pins,
	input wire logic [7:0] portc_pins,
	input wire logic [3:0] porte_pins,
	input wire logic debugger_enable,
	input wire logic reset_pin_function_enable,
	input wire logic low_voltage_programming,
	input wire logic change_irq_request,
	input wire logic wake_request,
	input wire logic irq
);
	logic [27:0] pins_q; // last pin sample
	logic [5:0] recent; // a pin moved within the last six clocks
	wire logic acc = psel && penable; // access phase
	wire logic wr_acc = acc && pwrite; // write taking effect
	wire logic [27:0] pins_now = {porta_pins, portb_pins, portc_pins, porte_pins};
	// pin history, so a new request can be traced back to a real pin change
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pins_q <= 28'h0;
			recent <= 6'h0;
		end else begin
			pins_q <= pins_now;
			recent <= {recent[4:0], pins_q != pins_now};
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	slverr_access_a: assert property (pslverr |-> acc) else $error("error outside access");
	slverr_unmapped_a: assert property (acc && paddr > 8'h3C |-> pslverr) else $error("unmapped not refused");
	wake_match_a: assert property (wake_request == change_irq_request) else $error("wake differs");
	req_cause_a: assert property ($rose(change_irq_request) |-> $past(wr_acc) || (|recent))
		else $error("request without cause");
	req_hold_a: assert property ($fell(change_irq_request) |-> $past(wr_acc)
		|| $past(debugger_enable || reset_pin_function_enable || low_voltage_programming))
		else $error("request dropped alone");
	irq_hold_a: assert property ($fell(irq) |-> $past(wr_acc)) else $error("irq dropped alone");
	master_off_a: assert property (wr_acc && paddr == 8'h30 && !pwdata[4] |=> !change_irq_request && !irq)
		else $error("request while master off");
	prdata_hold_a: assert property (!$past(psel && !penable && !pwrite) |-> $stable(prdata))
		else $error("read data moved");
	cover property (acc && !pwrite);
	cover property ($rose(change_irq_request));
	cover property ($rose(irq));
endmodule // pcint_ctrl_properties
`default_nettype wire

// ==== pcint_ctrl_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "pcint_defines.vh"
// self-checking bench for the pin change block
module pcint_ctrl_tb;
	logic pclk = 1'b0;
	logic presetn, psel, penable, pwrite, e;
	logic debugger_enable, reset_pin_function_enable, low_voltage_programming;
	logic [7:0] paddr;
	logic [31:0] pwdata, d;
	wire logic [31:0] prdata;
	wire logic pready, pslverr, change_irq_request, wake_request, irq;
	wire logic [7:0] porta_pins, portb_pins, portc_pins;
	wire logic [3:0] porte_pins;
	int mismatches = 0;
	int compares = 0;
	// 125 MHz bus clock
	always #4 pclk = ~pclk;
	pcint_ctrl #(.ADDR_W(8)) u_pcint_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.porta_pins(porta_pins), .portb_pins(portb_pins), .portc_pins(portc_pins), .porte_pins(porte_pins),
		.debugger_enable(debugger_enable), .reset_pin_function_enable(reset_pin_function_enable),
		.low_voltage_programming(low_voltage_programming), .change_irq_request(change_irq_request),
		.wake_request(wake_request), .irq(irq));
	pcint_pins_model u_pcint_pins_model (.pclk(pclk), .porta_pins(porta_pins), .portb_pins(portb_pins),
		.portc_pins(portc_pins), .porte_pins(porte_pins));
	task automatic final_report;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one apb transfer; request held until pready is sampled high, only the watchdog ends a wait
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
		output logic er);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		apb(1'b1, a, v, d, e);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0, d, e);
		chk($sformatf("register %h", a), exp, d);
	endtask
	// pin change then the fixed three-clock flag latency plus margin
	task automatic pin(input int port, input logic [7:0] v);
		u_pcint_pins_model.drive(port, v);
		repeat (5) @(posedge pclk);
	endtask
	task automatic t_reset;
		for (int a = 0; a < 16; a++) rdc(8'(a * 4), 32'h0);
		apb(1'b0, 8'h40, 32'h0, d, e);
		chk("unmapped error", 32'h1, {31'h0, e});
		chk("ready", 32'h1, {31'h0, pready});
	endtask
	// reset in mid-run: every register, the change request and irq must return to zero; wake_request is not checked
	task automatic t_rerun;
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		chk("request after reset", 32'h0, {31'h0, change_irq_request});
		chk("irq after reset", 32'h0, {31'h0, irq});
		t_reset();
	endtask
	task automatic t_edges;
		wr(`PCINT_OFF_PORTA_RISE, 32'h0F);
		wr(`PCINT_OFF_PORTA_FALL, 32'hF0);
		rdc(`PCINT_OFF_PORTA_FALL, 32'hF0);
		pin(0, 8'hFF);
		rdc(`PCINT_OFF_PORTA_FLAGS, 32'h0F);
		chk("request while master off", 32'h0, {31'h0, change_irq_request});
		pin(0, 8'h00);
		rdc(`PCINT_OFF_PORTA_FLAGS, 32'hFF);
		wr(`PCINT_OFF_PORTC_FALL, 32'h81);
		pin(2, 8'h81);
		pin(2, 8'h01);
		rdc(`PCINT_OFF_PORTC_FLAGS, 32'h80);
	endtask
	task automatic t_master;
		wr(`PCINT_OFF_PERIPHERAL_IRQ_ENABLE_0, 32'h10);
		@(posedge pclk);
		chk("request", 32'h1, {31'h0, change_irq_request});
		chk("wake", 32'h1, {31'h0, wake_request});
		rdc(`PCINT_OFF_PERIPHERAL_IRQ_REQUEST_0, 32'h10);
		apb(1'b0, `PCINT_OFF_PORTA_FLAGS, 32'h0, d, e);
		wr(`PCINT_OFF_PORTA_FLAGS, d & (32'hFF ^ d));
		rdc(`PCINT_OFF_PORTA_FLAGS, 32'h0);
		chk("request from port c", 32'h1, {31'h0, change_irq_request});
		wr(`PCINT_OFF_PORTC_FLAGS, 32'h0);
		rdc(`PCINT_OFF_PERIPHERAL_IRQ_REQUEST_0, 32'h0);
		u_pcint_pins_model.drive(0, 8'h01);
		wr(`PCINT_OFF_PORTA_FLAGS, 32'h0);
		rdc(`PCINT_OFF_PORTA_FLAGS, 32'h01);
	endtask
	task automatic t_irq;
		rdc(`PCINT_OFF_IRQ_STATUS, 32'h05);
		wr(`PCINT_OFF_IRQ_MASK, 32'h02);
		@(posedge pclk);
		chk("masked irq", 32'h0, {31'h0, irq});
		wr(`PCINT_OFF_IRQ_MASK, 32'h01);
		@(posedge pclk);
		chk("irq", 32'h1, {31'h0, irq});
		wr(`PCINT_OFF_IRQ_STATUS, 32'h01);
		@(posedge pclk);
		chk("cleared irq", 32'h0, {31'h0, irq});
		rdc(`PCINT_OFF_IRQ_STATUS, 32'h04);
		wr(`PCINT_OFF_PERIPHERAL_IRQ_ENABLE_0, 32'h0);
		@(posedge pclk);
		chk("request master off", 32'h0, {31'h0, change_irq_request});
		chk("wake master off", 32'h0, {31'h0, wake_request});
		rdc(`PCINT_OFF_PERIPHERAL_IRQ_REQUEST_0, 32'h10);
	endtask
	task automatic t_avail;
		debugger_enable <= 1'b1;
		wr(`PCINT_OFF_PORTB_RISE, 32'hFF);
		rdc(`PCINT_OFF_PORTB_RISE, 32'h3F);
		pin(1, 8'hFF);
		rdc(`PCINT_OFF_PORTB_FLAGS, 32'h3F);
		wr(`PCINT_OFF_PORTE_RISE, 32'hFF);
		rdc(`PCINT_OFF_PORTE_RISE, 32'h08);
		reset_pin_function_enable <= 1'b1;
		pin(3, 8'h0F);
		rdc(`PCINT_OFF_PORTE_FLAGS, 32'h0);
		reset_pin_function_enable <= 1'b0;
		low_voltage_programming <= 1'b1;
		pin(3, 8'h00);
		pin(3, 8'h08);
		rdc(`PCINT_OFF_PORTE_FLAGS, 32'h0);
		low_voltage_programming <= 1'b0;
		pin(3, 8'h00);
		pin(3, 8'h08);
		rdc(`PCINT_OFF_PORTE_FLAGS, 32'h08);
	endtask
	// main sequence: reset held 16 clocks, then every scenario in turn
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{debugger_enable, reset_pin_function_enable, low_voltage_programming} = 3'h0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_edges();
		t_master();
		t_irq();
		t_avail();
		t_rerun();
		final_report();
	end
	// watchdog: the run needs well under 2000 clocks
	initial begin
		#200000;
		mismatches++;
		final_report();
	end
endmodule // pcint_ctrl_tb
bind pcint_ctrl pcint_ctrl_properties #(.ADDR_W(ADDR_W)) u_pcint_ctrl_properties (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pslverr(pslverr), .porta_pins(porta_pins), .portb_pins(portb_pins),
	.portc_pins(portc_pins), .porte_pins(porte_pins), .debugger_enable(debugger_enable),
	.reset_pin_function_enable(reset_pin_function_enable), .low_voltage_programming(low_voltage_programming),
	.change_irq_request(change_irq_request), .wake_request(wake_request), .irq(irq));
`default_nettype wire
